// File: verif/mpu_motion_profile_properties.sv
// Port assertions for the motion profile object block
module mpu_motion_profile_props (
    // Watched ports
    input wire logic        clk_sys_in,
    input wire logic        arst_n_in,
    input wire logic        od_wr_in,
    input wire logic        od_rd_in,
    input wire logic [15:0] od_index_in,
    input wire logic [7:0]  od_sub_in,
    input wire logic [31:0] od_wdata_in,
    input wire logic [31:0] od_rdata_out,
    input wire logic [7:0]  op_mode_in,
    input wire logic [1:0]  ramp_phase_in,
    input wire logic [31:0] pos_set_in,
    input wire logic [31:0] pos_cmd_out,
    input wire logic [31:0] jerk_limit_out,
    input wire logic        jerk_limited_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    wire [7:0] js = (od_wr_in && od_index_in == 16'h60a4) ? od_sub_in : 8'h00;
    property p_free; jerk_limited_out == (jerk_limit_out != 32'h0); endproperty
    a_free: assert property (p_free) else $error("jerk flag wrong");
    property p_j1; js == 8'h01 ##1 ramp_phase_in == 2'h0 |=> jerk_limit_out == $past(od_wdata_in, 2); endproperty
    a_j1: assert property (p_j1) else $error("jerk 1 wrong");
    property p_j2; js == 8'h02 ##1 ramp_phase_in == 2'h1 |=> jerk_limit_out == $past(od_wdata_in, 2); endproperty
    a_j2: assert property (p_j2) else $error("jerk 2 wrong");
    property p_j3; js == 8'h03 ##1 ramp_phase_in == 2'h2 |=> jerk_limit_out == $past(od_wdata_in, 2); endproperty
    a_j3: assert property (p_j3) else $error("jerk 3 wrong");
    property p_j4; js == 8'h04 ##1 ramp_phase_in == 2'h3 |=> jerk_limit_out == $past(od_wdata_in, 2); endproperty
    a_j4: assert property (p_j4) else $error("jerk 4 wrong");
    property p_pu; od_rd_in && od_index_in == 16'h60a8 |=> od_rdata_out[15:0] == 16'h0; endproperty
    a_pu: assert property (p_pu) else $error("position unit low bits set");
    property p_vu; od_rd_in && od_index_in == 16'h60a9 |=> od_rdata_out[7:0] == 8'h0; endproperty
    a_vu: assert property (p_vu) else $error("velocity unit low bits set");
    property p_raw; op_mode_in != 8'h08 |=> pos_cmd_out == $past(pos_set_in); endproperty
    a_raw: assert property (p_raw) else $error("position offset applied");
endmodule
bind mpu_motion_profile mpu_motion_profile_props mpu_motion_profile_props_i (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .od_wr_in(od_wr_in), .od_rd_in(od_rd_in),
    .od_index_in(od_index_in), .od_sub_in(od_sub_in), .od_wdata_in(od_wdata_in), .od_rdata_out(od_rdata_out),
    .op_mode_in(op_mode_in), .ramp_phase_in(ramp_phase_in), .pos_set_in(pos_set_in), .pos_cmd_out(pos_cmd_out),
    .jerk_limit_out(jerk_limit_out), .jerk_limited_out(jerk_limited_out));

// File: verif/mpu_od_master.sv
// Fieldbus master model issuing object reads and writes
module mpu_od_master (
    // Answer side
    input  wire logic        clk_sys_in,
    input  wire logic        od_ack_in,
    input  wire logic        od_err_in,
    input  wire logic [31:0] od_rdata_in,
    // Request side
    output logic             od_wr_out,
    output logic             od_rd_out,
    output logic      [15:0] od_index_out,
    output logic      [7:0]  od_sub_out,
    output logic      [31:0] od_wdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {od_wr_out, od_rd_out, od_index_out, od_sub_out, od_wdata_out} = '0;
    // One-cycle request, answer stands one cycle later
    task automatic access(input logic wr, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                          output logic e, output logic [31:0] r);
        @(posedge clk_sys_in);
        {od_wr_out, od_rd_out} <= {wr, !wr};
        {od_index_out, od_sub_out, od_wdata_out} <= {i, s, d};
        @(posedge clk_sys_in);
        {od_wr_out, od_rd_out} <= 2'b00;
        // Released lines must not keep the old value
        {od_index_out, od_sub_out, od_wdata_out} <= ~{i, s, d};
        @(posedge clk_sys_in);
        e = od_err_in | !od_ack_in;
        r = od_rdata_in;
    endtask
endmodule

// File: verif/tb_mpu_motion_profile.sv
// Self-checking bench for the motion profile object block
module tb_mpu_motion_profile;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys_in = 1'b0;
    logic        arst_n_in = 1'b0;
    logic [7:0]  op_mode_in = 8'h00;
    logic [1:0]  ramp_phase_in = 2'h0;
    logic [31:0] pos_set_in = 32'd100;
    logic [31:0] vel_set_in = 32'd200;
    logic [15:0] trq_set_in = 16'd50;
    logic        od_wr_in, od_rd_in, od_ack_out, od_err_out, jerk_limited_out;
    logic [15:0] od_index_in, trq_cmd_out;
    logic [7:0]  od_sub_in, pos_unit_code_out, pos_unit_exp_out, vel_pos_code_out, vel_time_code_out, vel_unit_exp_out;
    logic [31:0] od_wdata_in, od_rdata_out, pos_cmd_out, vel_cmd_out, jerk_limit_out;
    logic [7:0]  modes [5] = '{8'h08, 8'h09, 8'h0a, 8'hff, 8'h01};
    int          fails = 0;
    int          cmp_count = 0;
    mpu_motion_profile mpu_motion_profile_i (
        .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .od_wr_in(od_wr_in), .od_rd_in(od_rd_in),
        .od_index_in(od_index_in), .od_sub_in(od_sub_in), .od_wdata_in(od_wdata_in), .od_rdata_out(od_rdata_out),
        .od_ack_out(od_ack_out), .od_err_out(od_err_out), .op_mode_in(op_mode_in), .ramp_phase_in(ramp_phase_in),
        .pos_set_in(pos_set_in), .vel_set_in(vel_set_in), .trq_set_in(trq_set_in), .pos_cmd_out(pos_cmd_out),
        .vel_cmd_out(vel_cmd_out), .trq_cmd_out(trq_cmd_out), .jerk_limit_out(jerk_limit_out),
        .jerk_limited_out(jerk_limited_out), .pos_unit_code_out(pos_unit_code_out),
        .pos_unit_exp_out(pos_unit_exp_out), .vel_pos_code_out(vel_pos_code_out),
        .vel_time_code_out(vel_time_code_out), .vel_unit_exp_out(vel_unit_exp_out));
    mpu_od_master mpu_od_master_i (
        .clk_sys_in(clk_sys_in), .od_ack_in(od_ack_out), .od_err_in(od_err_out), .od_rdata_in(od_rdata_out),
        .od_wr_out(od_wr_in), .od_rd_out(od_rd_in), .od_index_out(od_index_in), .od_sub_out(od_sub_in),
        .od_wdata_out(od_wdata_in));
    initial forever #50 clk_sys_in = ~clk_sys_in;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Reads compare the data against d
    task automatic acc(input logic wr, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic bad);
        logic        e;
        logic [31:0] r;
        mpu_od_master_i.access(wr, i, s, d, e, r);
        chk("refusal", {31'h0, e}, {31'h0, bad});
        if (!wr) chk("read data", r, d);
    endtask
    task finish_test;
        if (fails == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_sys_in);
        fails++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        for (int k = 1; k < 5; k++) acc(1'b0, 16'h60a4, k[7:0], 32'h3e8, 1'b0);
        acc(1'b0, 16'h60a8, 8'h00, 32'hff410000, 1'b0);
        acc(1'b0, 16'h60a9, 8'h00, 32'h00b44700, 1'b0);
        chk("units", {pos_unit_exp_out, pos_unit_code_out, vel_time_code_out, vel_unit_exp_out}, 32'hff414700);
        // Count entry is read-only, unknown object refused
        acc(1'b1, 16'h60a4, 8'h00, 32'h9, 1'b1);
        acc(1'b1, 16'h60a5, 8'h00, 32'h9, 1'b1);
        acc(1'b0, 16'h60a4, 8'h00, 32'h4, 1'b0);
        // Third segment set to zero, so unlimited
        for (int k = 0; k < 4; k++) begin
            ramp_phase_in <= k[1:0];
            acc(1'b1, 16'h60a4, k[7:0] + 8'h1, (k == 2) ? 32'h0 : 32'h100 * (k + 1), 1'b0);
            repeat (2) @(posedge clk_sys_in);
            chk("jerk", jerk_limit_out, (k == 2) ? 32'h0 : 32'h100 * (k + 1));
            chk("limited", {31'h0, jerk_limited_out}, {31'h0, k != 2});
        end
        acc(1'b1, 16'h60a8, 8'h00, 32'hffffffff, 1'b0);
        acc(1'b1, 16'h60a9, 8'h00, 32'h12345678, 1'b0);
        acc(1'b0, 16'h60a8, 8'h00, 32'hffff0000, 1'b0);
        acc(1'b0, 16'h60a9, 8'h00, 32'h12345600, 1'b0);
        chk("units", {vel_unit_exp_out, vel_pos_code_out, vel_time_code_out, pos_unit_code_out}, 32'h123456ff);
        acc(1'b1, 16'h60b0, 8'h00, 32'h5, 1'b0);
        acc(1'b1, 16'h60b1, 8'h00, 32'hfffffffd, 1'b0);
        acc(1'b1, 16'h60b2, 8'h00, 32'hfff6, 1'b0);
        acc(1'b0, 16'h60b2, 8'h00, 32'hfff6, 1'b0);
        foreach (modes[m]) begin
            op_mode_in <= modes[m];
            repeat (3) @(posedge clk_sys_in);
            chk("pos", pos_cmd_out, (m == 0) ? 32'd105 : 32'd100);
            chk("vel", vel_cmd_out, (m == 0 || m == 1 || m == 3) ? 32'd197 : 32'd200);
            chk("trq", {16'h0, trq_cmd_out}, (m == 0 || m == 2 || m == 3) ? 32'd40 : 32'd50);
        end
        finish_test();
    end
endmodule

// File: verilog/mpu_motion_profile.v
// Object dictionary entries for jerk limits, units and set-value offsets of the motion profile
`include "mpu_regs.vh"
module mpu_motion_profile (
    // Clock and reset
    input  wire        clk_sys_in,
    input  wire        arst_n_in,
    // Object dictionary access
    input  wire        od_wr_in,
    input  wire        od_rd_in,
    input  wire [15:0] od_index_in,
    input  wire [7:0]  od_sub_in,
    input  wire [31:0] od_wdata_in,
    output reg  [31:0] od_rdata_out,
    output reg         od_ack_out,
    output reg         od_err_out,
    // Operating mode and ramp phase
    input  wire [7:0]  op_mode_in,
    input  wire [1:0]  ramp_phase_in,
    // Raw set values
    input  wire [31:0] pos_set_in,
    input  wire [31:0] vel_set_in,
    input  wire [15:0] trq_set_in,
    // Conditioned set values
    output reg  [31:0] pos_cmd_out,
    output reg  [31:0] vel_cmd_out,
    output reg  [15:0] trq_cmd_out,
    // Jerk for the active ramp phase
    output reg  [31:0] jerk_limit_out,
    output reg         jerk_limited_out,
    // Unit fields for downstream scaling
    output reg  [7:0]  pos_unit_code_out,
    output reg  [7:0]  pos_unit_exp_out,
    output reg  [7:0]  vel_pos_code_out,
    output reg  [7:0]  vel_time_code_out,
    output reg  [7:0]  vel_unit_exp_out
);
    // Entry count doubles as the number of jerk words held
    localparam integer JERK_N = `MPU_RST_JERK_COUNT;
    localparam integer JW     = 32;

    wire [JERK_N*JW-1:0] jerk_all;
    wire                 jerk_wr;

    reg  [31:0] pos_unit_q;
    reg  [31:0] vel_unit_q;
    reg  [31:0] pos_ofs_q;
    reg  [31:0] vel_ofs_q;
    reg  [15:0] trq_ofs_q;

    reg  [31:0] rdata_d;
    reg         hit_d;
    reg         ro_d;
    reg  [31:0] jerk_d;
    wire        mode_csp;
    wire        mode_csv;
    wire        mode_cst;
    wire        mode_cd;
    wire        pos_en;
    wire        vel_en;
    wire        trq_en;
    wire [31:0] pos_sum;
    wire [31:0] vel_sum;
    wire [15:0] trq_sum;

    // Object decode; writes to read-only or unknown entries are refused
    always @* begin
        rdata_d = 32'h00000000;
        hit_d   = 1'b1;
        ro_d    = 1'b0;
        case (od_index_in)
            `MPU_IDX_JERK: begin
                case (od_sub_in)
                    `MPU_SUB_COUNT: begin
                        rdata_d = {24'h000000, `MPU_RST_JERK_COUNT};
                        ro_d    = 1'b1;
                    end
                    `MPU_SUB_ACC_START: rdata_d = jerk_all[`MPU_PH_ACC_START*JW +: JW];
                    `MPU_SUB_DEC_START: rdata_d = jerk_all[`MPU_PH_DEC_START*JW +: JW];
                    `MPU_SUB_ACC_END:   rdata_d = jerk_all[`MPU_PH_ACC_END*JW +: JW];
                    `MPU_SUB_DEC_END:   rdata_d = jerk_all[`MPU_PH_DEC_END*JW +: JW];
                    default:            hit_d   = 1'b0;
                endcase
            end
            `MPU_IDX_POS_UNIT: rdata_d = pos_unit_q;
            `MPU_IDX_VEL_UNIT: rdata_d = vel_unit_q;
            `MPU_IDX_POS_OFS:  rdata_d = pos_ofs_q;
            `MPU_IDX_VEL_OFS:  rdata_d = vel_ofs_q;
            `MPU_IDX_TRQ_OFS:  rdata_d = {16'h0000, trq_ofs_q};
            default:           hit_d   = 1'b0;
        endcase
    end

    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pos_unit_q       <= `MPU_RST_POS_UNIT;
            vel_unit_q       <= `MPU_RST_VEL_UNIT;
            pos_ofs_q        <= `MPU_RST_OFS32;
            vel_ofs_q        <= `MPU_RST_OFS32;
            trq_ofs_q        <= `MPU_RST_OFS16;
            od_rdata_out     <= 32'h00000000;
            od_ack_out       <= 1'b0;
            od_err_out       <= 1'b0;
        end else begin
            od_ack_out <= od_wr_in | od_rd_in;
            od_err_out <= (od_wr_in | od_rd_in) & (~hit_d | (od_wr_in & ro_d));
            if (od_rd_in && hit_d) begin
                od_rdata_out <= rdata_d;
            end
            if (od_wr_in && hit_d && !ro_d) begin
                case (od_index_in)
                    // Jerk words are written in their own per-entry loop
                    // Reserved low bits are forced to zero on write
                    `MPU_IDX_POS_UNIT: pos_unit_q <= od_wdata_in & `MPU_POS_UNIT_MASK;
                    `MPU_IDX_VEL_UNIT: vel_unit_q <= od_wdata_in & `MPU_VEL_UNIT_MASK;
                    `MPU_IDX_POS_OFS:  pos_ofs_q  <= od_wdata_in;
                    `MPU_IDX_VEL_OFS:  vel_ofs_q  <= od_wdata_in;
                    `MPU_IDX_TRQ_OFS:  trq_ofs_q  <= od_wdata_in[15:0];
                    default: ;
                endcase
            end
        end
    end

    // One word per ramp segment; sub-index n feeds segment n-1
    assign jerk_wr = od_wr_in & (od_index_in == `MPU_IDX_JERK);

    genvar g;
    generate
        for (g = 0; g < JERK_N; g = g + 1) begin : g_jerk
            reg  [JW-1:0] val_q;
            wire          we;

            assign we = jerk_wr & ({24'h000000, od_sub_in} == g + `MPU_SUB_ACC_START);
            always @(posedge clk_sys_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    val_q <= `MPU_RST_JERK;
                end else if (we) begin
                    // Any value is stored; zero later reads as no limit
                    val_q <= od_wdata_in;
                end
            end
            assign jerk_all[g*JW +: JW] = val_q;
        end
    endgenerate

    // Jerk selection by ramp phase
    // Phase codes double as word positions in jerk_all
    always @* begin
        case (ramp_phase_in)
            `MPU_PH_ACC_START: jerk_d = jerk_all[`MPU_PH_ACC_START*JW +: JW];
            `MPU_PH_DEC_START: jerk_d = jerk_all[`MPU_PH_DEC_START*JW +: JW];
            `MPU_PH_ACC_END:   jerk_d = jerk_all[`MPU_PH_ACC_END*JW +: JW];
            `MPU_PH_DEC_END:   jerk_d = jerk_all[`MPU_PH_DEC_END*JW +: JW];
            default:           jerk_d = jerk_all[`MPU_PH_ACC_START*JW +: JW];
        endcase
    end

    assign mode_csp = (op_mode_in == `MPU_MODE_CSP);
    assign mode_csv = (op_mode_in == `MPU_MODE_CSV);
    assign mode_cst = (op_mode_in == `MPU_MODE_CST);
    assign mode_cd  = (op_mode_in == `MPU_MODE_CLKDIR);
    assign pos_en   = mode_csp;
    assign vel_en   = mode_csp | mode_csv | mode_cd;
    assign trq_en   = mode_csp | mode_cst | mode_cd;

    mpu_offset_add #(.WIDTH(32)) u_pos_add (
        .set_in  (pos_set_in),
        .ofs_in  (pos_ofs_q),
        .en_in   (pos_en),
        .sum_out (pos_sum)
    );
    mpu_offset_add #(.WIDTH(32)) u_vel_add (
        .set_in  (vel_set_in),
        .ofs_in  (vel_ofs_q),
        .en_in   (vel_en),
        .sum_out (vel_sum)
    );
    mpu_offset_add #(.WIDTH(16)) u_trq_add (
        .set_in  (trq_set_in),
        .ofs_in  (trq_ofs_q),
        .en_in   (trq_en),
        .sum_out (trq_sum)
    );

    // Outputs registered: one cycle latency from set value and mode
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pos_cmd_out       <= 32'h00000000;
            vel_cmd_out       <= 32'h00000000;
            trq_cmd_out       <= 16'h0000;
            jerk_limit_out    <= `MPU_RST_JERK;
            jerk_limited_out  <= 1'b1;
            pos_unit_code_out <= 8'h00;
            pos_unit_exp_out  <= 8'h00;
            vel_pos_code_out  <= 8'h00;
            vel_time_code_out <= 8'h00;
            vel_unit_exp_out  <= 8'h00;
        end else begin
            pos_cmd_out       <= pos_sum;
            vel_cmd_out       <= vel_sum;
            trq_cmd_out       <= trq_sum;
            jerk_limit_out    <= jerk_d;
            // Zero selects an unlimited ramp segment
            jerk_limited_out  <= (jerk_d != 32'h00000000);
            pos_unit_code_out <= pos_unit_q[`MPU_UNIT_POS_MSB:`MPU_UNIT_POS_LSB];
            pos_unit_exp_out  <= pos_unit_q[`MPU_UNIT_EXP_MSB:`MPU_UNIT_EXP_LSB];
            vel_pos_code_out  <= vel_unit_q[`MPU_UNIT_POS_MSB:`MPU_UNIT_POS_LSB];
            vel_time_code_out <= vel_unit_q[`MPU_UNIT_TIME_MSB:`MPU_UNIT_TIME_LSB];
            vel_unit_exp_out  <= vel_unit_q[`MPU_UNIT_EXP_MSB:`MPU_UNIT_EXP_LSB];
        end
    end
endmodule

// File: verilog/mpu_offset_add.v
// Saturating signed adder that applies one offset to one set value when enabled
module mpu_offset_add #(
    parameter WIDTH = 32
) (
    // Operands
    input  wire signed [WIDTH-1:0] set_in,
    input  wire signed [WIDTH-1:0] ofs_in,
    input  wire                    en_in,
    // Result
    output wire signed [WIDTH-1:0] sum_out
);
    wire signed [WIDTH:0] wide_sum;
    wire                  ovf;
    wire [WIDTH-1:0]      sat_val;

    assign wide_sum = {set_in[WIDTH-1], set_in} + {ofs_in[WIDTH-1], ofs_in};
    // Clamp rather than wrap: a wrapped set value would reverse the motor
    assign ovf      = wide_sum[WIDTH] ^ wide_sum[WIDTH-1];
    assign sat_val  = {wide_sum[WIDTH], {(WIDTH-1){~wide_sum[WIDTH]}}};
    assign sum_out  = en_in ? (ovf ? sat_val : wide_sum[WIDTH-1:0]) : set_in;
endmodule

// File: verilog/mpu_regs.vh
// Object indices, sub-indices, field positions, reset values and mode codes of the motion profile block
`ifndef MPU_REGS_VH
`define MPU_REGS_VH
`define MPU_IDX_JERK          16'h60a4
`define MPU_IDX_POS_UNIT      16'h60a8
`define MPU_IDX_VEL_UNIT      16'h60a9
`define MPU_IDX_POS_OFS       16'h60b0
`define MPU_IDX_VEL_OFS       16'h60b1
`define MPU_IDX_TRQ_OFS       16'h60b2
`define MPU_SUB_COUNT         8'h00
`define MPU_SUB_ACC_START     8'h01
`define MPU_SUB_DEC_START     8'h02
`define MPU_SUB_ACC_END       8'h03
`define MPU_SUB_DEC_END       8'h04
`define MPU_RST_JERK_COUNT    8'h04
`define MPU_RST_JERK          32'h000003e8
`define MPU_RST_POS_UNIT      32'hff410000
`define MPU_RST_VEL_UNIT      32'h00b44700
`define MPU_RST_OFS32         32'h00000000
`define MPU_RST_OFS16         16'h0000
`define MPU_POS_UNIT_MASK     32'hffff0000
`define MPU_VEL_UNIT_MASK     32'hffffff00
`define MPU_UNIT_EXP_MSB      31
`define MPU_UNIT_EXP_LSB      24
`define MPU_UNIT_POS_MSB      23
`define MPU_UNIT_POS_LSB      16
`define MPU_UNIT_TIME_MSB     15
`define MPU_UNIT_TIME_LSB     8
`define MPU_MODE_CSP          8'h08
`define MPU_MODE_CSV          8'h09
`define MPU_MODE_CST          8'h0a
`define MPU_MODE_CLKDIR       8'hff
`define MPU_PH_ACC_START      2'h0
`define MPU_PH_DEC_START      2'h1
`define MPU_PH_ACC_END        2'h2
`define MPU_PH_DEC_END        2'h3
`endif
